/* led_if_pkg.sv */
package led_if_pkg;
	// Two-wire target address and register indices.
	localparam logic [6:0] TARGET_ADDR = 7'h32;
	localparam logic [7:0] MISC_INDEX = 8'h36;
	localparam logic [7:0] STATUS_INDEX = 8'h3a;
	localparam logic [7:0] PIN_CTRL_INDEX = 8'h3b;
	localparam logic [7:0] NO_STEP_LO = 8'h16;
	localparam logic [7:0] NO_STEP_HI = 8'h1e;
	localparam logic [7:0] INDEX_ONE = 8'h01;

	// Field positions.
	localparam int ALERT_MODE_BIT = 2;
	localparam int GEN_OUT_BIT = 1;
	localparam int ALERT_LEVEL_BIT = 0;
	localparam int STEP_EN_BIT = 6;
	localparam int PSAVE_EN_BIT = 5;
	localparam int INT_PEND_BIT = 0;
	localparam logic [7:0] MISC_RESET = 8'h00;
	localparam logic [7:0] PIN_CTRL_RESET = 8'h00;

	// Byte framing.
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] BIT_ONE = 4'h1;

	// Trigger timing in cycles of the 32 kHz link clock.
	localparam logic [1:0] TRIGGER_LINE_RX_MIN = 2'h2;
	localparam logic [2:0] TRIGGER_LINE_TX_LEN = 3'h3;
	localparam logic [2:0] TRIGGER_LINE_MASK_LEN = 3'h6;

	// Clock figures.
	localparam int MCLK_HZ = 125000000;
	localparam int MCLK_PERIOD_NS = 8;
	localparam int EXT_CLK_HZ = 32000;
	localparam int EXT_PERIOD_NS = 1000000000 / EXT_CLK_HZ;
	// External clock counts as lost after two missing periods, rounded down.
	localparam int EXT_LOSS_CYCLES = (2 * EXT_PERIOD_NS) / MCLK_PERIOD_NS;
	localparam int FILTER_CYCLES = 4;

	typedef enum logic [6:0] {
		S_IDLE = 7'h01,
		S_ADDR = 7'h02,
		S_INDEX = 7'h04,
		S_WDATA = 7'h08,
		S_ACK = 7'h10,
		S_RDATA = 7'h20,
		S_MACK = 7'h40
	} tw_state_t;
endpackage

/* led_if_props.sv */
`timescale 1ns/1ns
`default_nettype none
module led_if_props (
	// Clocks and reset
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_ext_clk,
	// Watched ports
	input wire logic o_sda,
	input wire logic o_sda_oe_n,
	input wire logic o_alert_oe_n,
	input wire logic o_general_output,
	input wire logic o_trigger_line,
	input wire logic o_trigger_oe_n,
	input wire logic o_trigger_line_received,
	input wire logic i_int_event,
	input wire logic i_power_save,
	input wire logic o_osc_off,
	input wire logic o_reg_wr,
	input wire logic [7:0] o_reg_addr
);
	sequence s_send_start;
		$fell(o_trigger_oe_n);
	endsequence
	sequence s_send_body;
		(!o_trigger_oe_n)[*3] ##1 o_trigger_oe_n;
	endsequence
	property p_trigger_line_len;
		@(posedge i_ext_clk) disable iff (i_sys_rst) s_send_start |-> s_send_body;
	endproperty
	a_trigger_line_len: assert property (p_trigger_line_len) else $error("trigger length");
	property p_trigger_line_mask;
		@(posedge i_mclk) disable iff (i_sys_rst) s_send_start |-> (!o_trigger_line_received)[*8];
	endproperty
	a_trigger_line_mask: assert property (p_trigger_line_mask) else $error("own trigger seen");
	property p_trigger_line_od;
		@(posedge i_mclk) disable iff (i_sys_rst) !o_trigger_oe_n |-> !o_trigger_line;
	endproperty
	a_trigger_line_od: assert property (p_trigger_line_od) else $error("trigger drives high");
	property p_sda_low;
		@(posedge i_mclk) disable iff (i_sys_rst) !o_sda_oe_n |-> !o_sda;
	endproperty
	a_sda_low: assert property (p_sda_low) else $error("data drives high");
	property p_int_set;
		@(posedge i_mclk) disable iff (i_sys_rst) i_int_event |-> ##[1:4] !o_alert_oe_n;
	endproperty
	a_int_set: assert property (p_int_set) else $error("alert not pulled");
	property p_addr_hold;
		@(posedge i_mclk) disable iff (i_sys_rst) !o_reg_wr |-> $stable(o_reg_addr);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("write index moved");
	property p_osc;
		@(posedge i_mclk) disable iff (i_sys_rst) o_osc_off |-> $past(i_power_save);
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator off early");
	property p_gen_out;
		@(posedge i_mclk) disable iff (i_sys_rst)
			$changed(o_general_output) |-> o_reg_wr || $past(o_reg_wr) || $past(o_reg_wr, 2);
	endproperty
	a_gen_out: assert property (p_gen_out) else $error("output moved alone");
endmodule
bind led_logic_if led_if_props u_props (.i_mclk, .i_sys_rst, .i_ext_clk, .o_sda, .o_sda_oe_n,
	.o_alert_oe_n, .o_general_output, .o_trigger_line, .o_trigger_oe_n, .o_trigger_line_received,
	.i_int_event, .i_power_save, .o_osc_off, .o_reg_wr, .o_reg_addr);
`default_nettype wire

/* led_logic_if.sv */
// How it works
// - Output register bit 2 picks alert line role: interrupt or general output.
// - Output register bit 1 sets the general output pin level.
// - Output register bit 0 sets alert line level in output role, reads back the alert line in interrupt role.
// - In interrupt role the alert line pulls low while an interrupt pends.
// - General output and alert output role are driven push-pull.
// - Trigger line is open drain, active low, both sent and received.
// - A received trigger needs at least two link clock cycles low.
// - A sent trigger holds the line low exactly three link clock cycles.
// - With external clock present, power-save turns the internal oscillator off.
// - Data changes only while the serial clock is low.
// - Start is data falling, stop is data rising, with clock high.
// - Repeated start behaves exactly like a first start.
// - Bytes are eight bits, most significant first, then one acknowledge pulse.
// - Target pulls data low in the ninth pulse after each received byte.
// - First byte holds seven address bits and a direction bit, 1 reads.
// - Target answers only address 32h, otherwise stays silent.
// - Written byte after address sets index, following bytes store data.
// - With step enable set in 36h, index advances after each written data byte outside 16h to 1Eh.
// - Index never advances after a written byte inside range 16h to 1Eh.
// - Each controller acknowledge on a read advances the index by one.
// - Reading status register 3Ah clears the pending interrupt.
// - The device ignores triggers on the line that it sent itself.
`timescale 1ns/1ns
`default_nettype none
module led_logic_if
	import led_if_pkg::*;
#(
	parameter int EXT_LOSS = EXT_LOSS_CYCLES,
	parameter int FILTER = FILTER_CYCLES
) (
	// Clocks and reset
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_ext_clk,
	// Two-wire serial bus
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe_n,
	// Alert line and general output
	input wire logic i_alert,
	output logic o_alert,
	output logic o_alert_oe_n,
	output logic o_general_output,
	// Trigger line
	input wire logic i_trigger_line,
	output logic o_trigger_line,
	output logic o_trigger_oe_n,
	// Core side
	input wire logic i_int_event,
	input wire logic i_trigger_line_send,
	output logic o_trigger_line_received,
	input wire logic i_power_save,
	output logic o_osc_off,
	// Remaining register map outside this block
	input wire logic [7:0] i_ext_rdata,
	output logic [7:0] o_reg_index,
	output logic o_reg_wr,
	output logic [7:0] o_reg_addr,
	output logic [7:0] o_reg_wdata
);
	tw_state_t state_q;
	logic [1:0] pin_s1_q, pin_s2_q, flt_q, flt_p_q;
	logic [3:0] bit_cnt_q;
	logic [7:0] shift_q, tx_q, index_q, misc_q, pin_ctrl_q;
	logic read_mode_q, after_addr_q, sda_oe_n_q, int_pend_q, read_clr_q;
	logic alert_s1_q, alert_s2_q;

	// two flops, then a level must hold FILTER cycles to be taken.
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			pin_s1_q <= 2'h3;
			pin_s2_q <= 2'h3;
			flt_p_q <= 2'h3;
		end else begin
			pin_s1_q <= {i_scl, i_sda};
			pin_s2_q <= pin_s1_q;
			flt_p_q <= flt_q;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_filter
			logic [7:0] cnt_q;
			always_ff @(posedge i_mclk) begin
				if (i_sys_rst) begin
					cnt_q <= 8'h00;
					flt_q[g] <= 1'b1;
				end else if (pin_s2_q[g] == flt_q[g]) begin
					cnt_q <= 8'h00;
				end else if (cnt_q == 8'(FILTER - 1)) begin
					cnt_q <= 8'h00;
					flt_q[g] <= pin_s2_q[g];
				end else begin
					cnt_q <= cnt_q + 8'h01;
				end
			end
		end
	endgenerate

	wire scl_f = flt_q[1];
	wire sda_f = flt_q[0];
	wire scl_rise = scl_f & ~flt_p_q[1];
	wire scl_fall = ~scl_f & flt_p_q[1];
	// data edges only count as conditions while the clock is high.
	wire start_cond = scl_f & flt_p_q[1] & flt_p_q[0] & ~sda_f;
	wire stop_cond = scl_f & flt_p_q[1] & ~flt_p_q[0] & sda_f;
	wire byte_done = (bit_cnt_q == BYTE_BITS);
	wire addr_match = (shift_q[7:1] == TARGET_ADDR);
	wire in_no_step = (index_q >= NO_STEP_LO) && (index_q <= NO_STEP_HI);
	wire write_step = misc_q[STEP_EN_BIT] & ~in_no_step;
	wire alert_as_output = pin_ctrl_q[ALERT_MODE_BIT];
	wire [7:0] pin_ctrl_view = {pin_ctrl_q[7:1],
		alert_as_output ? pin_ctrl_q[ALERT_LEVEL_BIT] : alert_s2_q};
	wire [7:0] status_view = {7'h00, int_pend_q};
	wire [7:0] read_byte = (index_q == MISC_INDEX) ? misc_q :
		(index_q == STATUS_INDEX) ? status_view :
		(index_q == PIN_CTRL_INDEX) ? pin_ctrl_view : i_ext_rdata;
	wire load_tx = scl_fall && ((state_q == S_ACK && read_mode_q) || state_q == S_MACK);

	// Two-wire target.
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			state_q <= S_IDLE;
			bit_cnt_q <= 4'h0;
			shift_q <= 8'h00;
			tx_q <= 8'h00;
			index_q <= 8'h00;
			read_mode_q <= 1'b0;
			after_addr_q <= 1'b0;
			sda_oe_n_q <= 1'b1;
			read_clr_q <= 1'b0;
			o_reg_wr <= 1'b0;
			o_reg_addr <= 8'h00;
			o_reg_wdata <= 8'h00;
		end else begin
			o_reg_wr <= 1'b0;
			read_clr_q <= 1'b0;
			if (start_cond) begin
				state_q <= S_ADDR;
				bit_cnt_q <= 4'h0;
				sda_oe_n_q <= 1'b1;
			end else if (stop_cond) begin
				state_q <= S_IDLE;
				sda_oe_n_q <= 1'b1;
			end else if (scl_rise) begin
				case (state_q)
				S_ADDR, S_INDEX, S_WDATA: begin
					shift_q <= {shift_q[6:0], sda_f};
					bit_cnt_q <= bit_cnt_q + BIT_ONE;
				end
				S_MACK: begin
					if (sda_f)
						state_q <= S_IDLE;
					else
						index_q <= index_q + INDEX_ONE;
				end
				default: begin
				end
				endcase
			end else if (load_tx) begin
				// Reading the status register hands the pending flag over and clears it.
				sda_oe_n_q <= read_byte[7];
				tx_q <= {read_byte[6:0], 1'b0};
				bit_cnt_q <= BIT_ONE;
				read_clr_q <= (index_q == STATUS_INDEX);
				state_q <= S_RDATA;
			end else if (scl_fall) begin
				case (state_q)
				S_ADDR: begin
					if (byte_done && addr_match) begin
						sda_oe_n_q <= 1'b0;
						read_mode_q <= shift_q[0];
						after_addr_q <= 1'b1;
						state_q <= S_ACK;
					end else if (byte_done) begin
						state_q <= S_IDLE;
					end
				end
				S_INDEX: begin
					if (byte_done) begin
						index_q <= shift_q;
						sda_oe_n_q <= 1'b0;
						after_addr_q <= 1'b0;
						state_q <= S_ACK;
					end
				end
				S_WDATA: begin
					if (byte_done) begin
						o_reg_wr <= 1'b1;
						o_reg_addr <= index_q;
						o_reg_wdata <= shift_q;
						if (write_step)
							index_q <= index_q + INDEX_ONE;
						sda_oe_n_q <= 1'b0;
						state_q <= S_ACK;
					end
				end
				S_ACK: begin
					sda_oe_n_q <= 1'b1;
					bit_cnt_q <= 4'h0;
					state_q <= after_addr_q ? S_INDEX : S_WDATA;
				end
				S_RDATA: begin
					if (byte_done) begin
						sda_oe_n_q <= 1'b1;
						state_q <= S_MACK;
					end else begin
						sda_oe_n_q <= tx_q[7];
						tx_q <= {tx_q[6:0], 1'b0};
						bit_cnt_q <= bit_cnt_q + BIT_ONE;
					end
				end
				default: begin
				end
				endcase
			end
		end
	end

	// Local registers, the status flag, and the pins driven from them.
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			misc_q <= MISC_RESET;
			pin_ctrl_q <= PIN_CTRL_RESET;
			int_pend_q <= 1'b0;
			alert_s1_q <= 1'b1;
			alert_s2_q <= 1'b1;
			o_sda <= 1'b0;
			o_sda_oe_n <= 1'b1;
			o_alert <= 1'b0;
			o_alert_oe_n <= 1'b1;
			o_general_output <= 1'b0;
			o_reg_index <= 8'h00;
		end else begin
			if (o_reg_wr && o_reg_addr == MISC_INDEX)
				misc_q <= o_reg_wdata;
			if (o_reg_wr && o_reg_addr == PIN_CTRL_INDEX)
				pin_ctrl_q <= o_reg_wdata;
			// A new event in the clearing cycle keeps the flag set.
			int_pend_q <= i_int_event | (int_pend_q & ~read_clr_q);
			alert_s1_q <= i_alert;
			alert_s2_q <= alert_s1_q;
			o_sda <= 1'b0;
			o_sda_oe_n <= sda_oe_n_q;
			o_general_output <= pin_ctrl_q[GEN_OUT_BIT];
			if (alert_as_output) begin
				o_alert <= pin_ctrl_q[ALERT_LEVEL_BIT];
				o_alert_oe_n <= 1'b0;
			end else begin
				o_alert <= 1'b0;
				o_alert_oe_n <= ~int_pend_q;
			end
			o_reg_index <= index_q;
		end
	end

	// Link clock domain: trigger line sender and receiver.
	logic xrst_s1_q, xrst_q, send_s1_q, send_s2_q, send_s3_q, send_tgl_q;
	logic trigger_line_s1_q, trigger_line_s2_q, rx_tgl_q;
	logic [2:0] tx_cnt_q, mask_cnt_q;
	logic [1:0] low_cnt_q;

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst)
			send_tgl_q <= 1'b0;
		else if (i_trigger_line_send)
			send_tgl_q <= ~send_tgl_q;
	end

	always_ff @(posedge i_ext_clk) begin
		xrst_s1_q <= i_sys_rst;
		xrst_q <= xrst_s1_q;
	end

	always_ff @(posedge i_ext_clk) begin
		if (xrst_q) begin
			send_s1_q <= 1'b0;
			send_s2_q <= 1'b0;
			send_s3_q <= 1'b0;
			trigger_line_s1_q <= 1'b1;
			trigger_line_s2_q <= 1'b1;
			tx_cnt_q <= 3'h0;
			mask_cnt_q <= 3'h0;
			low_cnt_q <= 2'h0;
			rx_tgl_q <= 1'b0;
			o_trigger_line <= 1'b0;
			o_trigger_oe_n <= 1'b1;
		end else begin
			send_s1_q <= send_tgl_q;
			send_s2_q <= send_s1_q;
			send_s3_q <= send_s2_q;
			trigger_line_s1_q <= i_trigger_line;
			trigger_line_s2_q <= trigger_line_s1_q;
			o_trigger_line <= 1'b0;
			if (send_s2_q != send_s3_q) begin
				tx_cnt_q <= TRIGGER_LINE_TX_LEN;
				mask_cnt_q <= TRIGGER_LINE_MASK_LEN;
				o_trigger_oe_n <= 1'b0;
			end else begin
				if (tx_cnt_q != 3'h0)
					tx_cnt_q <= tx_cnt_q - 3'h1;
				if (mask_cnt_q != 3'h0)
					mask_cnt_q <= mask_cnt_q - 3'h1;
				o_trigger_oe_n <= (tx_cnt_q <= 3'h1);
			end
			// The mask outlasts the pulse by the synchroniser delay so our own low is never seen.
			if (trigger_line_s2_q || mask_cnt_q != 3'h0) begin
				low_cnt_q <= 2'h0;
			end else if (low_cnt_q != TRIGGER_LINE_RX_MIN) begin
				low_cnt_q <= low_cnt_q + 2'h1;
				if (low_cnt_q == TRIGGER_LINE_RX_MIN - 2'h1)
					rx_tgl_q <= ~rx_tgl_q;
			end
		end
	end

	// Back in the system domain: received triggers and external clock presence.
	logic rx_s1_q, rx_s2_q, rx_s3_q, ext_s1_q, ext_s2_q, ext_s3_q, ext_tgl_q, ext_present_q;
	logic [15:0] loss_cnt_q;

	always_ff @(posedge i_ext_clk) begin
		if (xrst_q)
			ext_tgl_q <= 1'b0;
		else
			ext_tgl_q <= ~ext_tgl_q;
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			rx_s1_q <= 1'b0;
			rx_s2_q <= 1'b0;
			rx_s3_q <= 1'b0;
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
			loss_cnt_q <= 16'h0000;
			ext_present_q <= 1'b0;
			o_trigger_line_received <= 1'b0;
			o_osc_off <= 1'b0;
		end else begin
			rx_s1_q <= rx_tgl_q;
			rx_s2_q <= rx_s1_q;
			rx_s3_q <= rx_s2_q;
			o_trigger_line_received <= rx_s2_q ^ rx_s3_q;
			ext_s1_q <= ext_tgl_q;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
			if (ext_s2_q != ext_s3_q) begin
				loss_cnt_q <= 16'h0000;
				ext_present_q <= 1'b1;
			end else if (loss_cnt_q == 16'(EXT_LOSS)) begin
				ext_present_q <= 1'b0;
			end else begin
				loss_cnt_q <= loss_cnt_q + 16'h0001;
			end
			o_osc_off <= ext_present_q & i_power_save & misc_q[PSAVE_EN_BIT];
		end
	end
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
	import led_if_pkg::*;
	logic i_mclk = 0, i_ext_clk = 0, i_sys_rst = 1, i_int_event = 0, i_trigger_line_send = 0;
	logic i_power_save = 0, trigger_line_low = 0, scl, sda_low, o_sda, o_sda_oe_n, o_alert;
	logic o_alert_oe_n, o_general_output, o_trigger_line, o_trigger_oe_n, o_trigger_line_received;
	logic o_osc_off, o_reg_wr;
	logic ext_run = 1;
	logic [7:0] o_reg_index, o_reg_addr, o_reg_wdata;
	int n_errors = 0, compares = 0;
	// Released lines float to their pull-ups.
	wire sda = !sda_low && (o_sda_oe_n || o_sda);
	wire alert = o_alert_oe_n || o_alert;
	wire trigger_line = !trigger_line_low && (o_trigger_oe_n || o_trigger_line);
	wire [7:0] rdata = o_reg_index ^ 8'h5a;
	initial forever #4 i_mclk = !i_mclk;
	initial begin
		#3;
		forever begin
			// Clearing ext_run stops the external clock so that its loss can be seen.
			#7 i_ext_clk = ext_run;
			#8 i_ext_clk = 0;
		end
	end
	led_logic_if #(.EXT_LOSS(20)) uut (.i_mclk, .i_sys_rst, .i_ext_clk, .i_scl(scl), .i_sda(sda),
		.o_sda, .o_sda_oe_n, .i_alert(alert), .o_alert, .o_alert_oe_n, .o_general_output,
		.i_trigger_line(trigger_line), .o_trigger_line, .o_trigger_oe_n, .i_int_event, .i_trigger_line_send,
		.o_trigger_line_received, .i_power_save, .o_osc_off, .i_ext_rdata(rdata), .o_reg_index,
		.o_reg_wr, .o_reg_addr, .o_reg_wdata);
	tw_host host (.i_mclk, .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic results;
		if (n_errors == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask
	task automatic sb(input logic [7:0] d);
		logic [7:0] q;
		logic a;
		host.xbyte(d, 1'b1, q, a);
		chk(8'(a), 8'h00);
	endtask
	task automatic rb(input logic nack, input logic [7:0] e);
		logic [7:0] q;
		logic a;
		host.xbyte(8'hff, nack, q, a);
		chk(q, e);
	endtask
	task automatic head(input logic [7:0] idx);
		host.start();
		sb({TARGET_ADDR, 1'b0});
		sb(idx);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		head(idx);
		sb(d);
		host.stop();
	endtask
	task automatic rd(input logic [7:0] idx, input logic nack, input logic [7:0] e);
		head(idx);
		host.start();
		sb({TARGET_ADDR, 1'b1});
		rb(nack, e);
		if (!nack) rb(1'b1, e + 8'h01);
		host.stop();
	endtask
	task automatic t_nack;
		logic [7:0] q;
		logic a;
		host.start();
		host.xbyte({7'h33, 1'b0}, 1'b1, q, a);
		host.stop();
		chk(8'(a), 8'h01);
	endtask
	task automatic t_pins;
		logic [7:0] v [3] = '{8'h06, 8'h05, 8'h00};
		foreach (v[i]) begin
			wr(PIN_CTRL_INDEX, v[i]);
			chk(8'(o_general_output), 8'(v[i][1]));
			chk(8'(o_alert_oe_n), 8'(!v[i][2]));
			chk(8'(alert), 8'(v[i][0] | !v[i][2]));
			rd(PIN_CTRL_INDEX, 1'b1, v[i] | 8'(!v[i][2]));
		end
	endtask
	task automatic t_step;
		logic [7:0] s [4] = '{8'h15, 8'h16, 8'h1e, 8'h1f};
		logic [7:0] e [4] = '{8'h16, 8'h16, 8'h1e, 8'h20};
		wr(MISC_INDEX, 8'h01 << STEP_EN_BIT);
		foreach (s[i]) begin
			head(s[i]);
			sb(8'ha0);
			chk(o_reg_addr, s[i]);
			sb(8'ha1);
			host.stop();
			chk(o_reg_addr, e[i]);
			chk(o_reg_wdata, 8'ha1);
		end
	endtask
	task automatic t_int;
		i_int_event = 1;
		cyc(1);
		i_int_event = 0;
		cyc(4);
		chk(8'(alert), 8'h00);
		rd(STATUS_INDEX, 1'b1, 8'h01);
		chk(8'(alert), 8'h01);
		rd(STATUS_INDEX, 1'b1, 8'h00);
	endtask
	task automatic watch(input int n, output int rx, output int lo);
		rx = 0;
		lo = 0;
		// The line is pulled inside the counting loop, because a received pulse can
		// arrive while the line is still held low and would otherwise be missed.
		for (int k = 0; k < 60; k++) begin
			trigger_line_low = (k < n);
			cyc(1);
			rx += int'(o_trigger_line_received === 1'b1);
			lo += int'(trigger_line === 1'b0);
		end
	endtask
	task automatic t_trigger_line;
		int rx, lo;
		int n [2] = '{1, 8};
		i_trigger_line_send = 1;
		cyc(1);
		i_trigger_line_send = 0;
		watch(0, rx, lo);
		chk(8'(lo > 4 && lo < 7), 8'h01);
		chk(8'(rx), 8'h00);
		foreach (n[i]) begin
			watch(n[i], rx, lo);
			chk(8'(rx), 8'(i));
		end
	endtask
	task automatic t_osc;
		wr(MISC_INDEX, 8'h01 << PSAVE_EN_BIT);
		i_power_save = 1;
		cyc(30);
		chk(8'(o_osc_off), 8'h01);
		i_power_save = 0;
		cyc(3);
		chk(8'(o_osc_off), 8'h00);
		// Once the external clock is lost the internal oscillator must be back on.
		i_power_save = 1;
		ext_run = 0;
		cyc(40);
		chk(8'(o_osc_off), 8'h00);
		ext_run = 1;
		i_power_save = 0;
	endtask
	initial begin
		// Six cycles so the link domain also sees three reset edges.
		cyc(6);
		i_sys_rst = 0;
		cyc(1);
		chk(8'(o_general_output), 8'h00);
		chk(8'(o_alert_oe_n), 8'h01);
		cyc(20);
		rd(PIN_CTRL_INDEX, 1'b1, PIN_CTRL_RESET | 8'h01);
		t_nack();
		t_pins();
		t_step();
		rd(8'h10, 1'b0, 8'h4a);
		t_int();
		t_trigger_line();
		t_osc();
		results();
	end
	initial begin
		repeat (95000) @(posedge i_mclk);
		n_errors++;
		results();
	end
endmodule
`default_nettype wire

/* tw_host.sv */
`timescale 1ns/1ns
`default_nettype none
module tw_host (
	// Clock and sensing
	input wire logic i_mclk,
	input wire logic i_sda,
	// Bus drive
	output logic o_scl,
	output logic o_sda_low
);
	initial begin
		o_scl = 1;
		o_sda_low = 0;
	end
	// Sixteen cycles a phase keeps every level well past the target's filter.
	task automatic gap;
		repeat (16) @(posedge i_mclk);
		#1;
	endtask
	task automatic xbit(input logic b, output logic r);
		o_scl = 0;
		gap();
		o_sda_low = !b;
		gap();
		o_scl = 1;
		gap();
		r = i_sda;
	endtask
	task automatic start;
		o_scl = 0;
		gap();
		o_sda_low = 0;
		gap();
		o_scl = 1;
		gap();
		o_sda_low = 1;
		gap();
	endtask
	task automatic stop;
		o_scl = 0;
		gap();
		o_sda_low = 1;
		gap();
		o_scl = 1;
		gap();
		o_sda_low = 0;
		gap();
	endtask
	task automatic xbyte(input logic [7:0] d, input logic k, output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
		xbit(k, a);
	endtask
endmodule
`default_nettype wire
